// ===== shared/ulms_params.svh
`ifndef ULMS_PARAMS_SVH
`define ULMS_PARAMS_SVH

// Register offsets on the plain register port
`define ULMS_OFS_DATA 3'h0
`define ULMS_OFS_IER  3'h1
`define ULMS_OFS_LCR  3'h3
`define ULMS_OFS_MCT  3'h4
`define ULMS_OFS_LST  3'h5
`define ULMS_OFS_MST  3'h6
`define ULMS_OFS_SCR  3'h7

// Line status field positions
`define ULMS_LST_EIF  7
`define ULMS_LST_ALLE 6
`define ULMS_LST_TXFE 5
`define ULMS_LST_BRK  4
`define ULMS_LST_FRM  3
`define ULMS_LST_PAR  2
`define ULMS_LST_OVR  1
`define ULMS_LST_RDY  0

// Control field positions
`define ULMS_IER_TXE  1
`define ULMS_LCR_PEN  3
`define ULMS_LCR_EPS  4
`define ULMS_MCT_DTR  0
`define ULMS_MCT_RTS  1
`define ULMS_MCT_AUX1 2
`define ULMS_MCT_AUX2 3
`define ULMS_MCT_LOOP 4

// Reset values
`define ULMS_IER_RST  8'h00
`define ULMS_LCR_RST  8'h00
`define ULMS_MCT_RST  8'h00
`define ULMS_SCR_RST  8'h00

// Timing: one bit time at the fixed line rate
`define ULMS_CLK_PERIOD_NS 100
`define ULMS_BIT_TIME_NS   8680
`define ULMS_BIT_CYC       (`ULMS_BIT_TIME_NS / `ULMS_CLK_PERIOD_NS)
`define ULMS_HALF_CYC      (`ULMS_BIT_CYC / 2)

// FIFO depth, both directions
`define ULMS_FIFO_DEPTH 16

`endif

// ===== shared/ulms_pkg.sv
package ulms_pkg;

    typedef enum logic [2:0] {
        ULMS_RX_IDLE, ULMS_RX_START, ULMS_RX_DATA, ULMS_RX_PARITY,
        ULMS_RX_STOP, ULMS_RX_HOLD, ULMS_RX_BRKEND
    } ulms_rx_e;

    typedef enum logic {ULMS_TX_IDLE, ULMS_TX_SEND} ulms_tx_e;

    typedef logic [7:0] ulms_byte_t;

endpackage

// ===== src/ulms_top.sv
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
`include "ulms_params.svh"
// Overview of operation
// - Bit 7 flags any errored character in receive FIFO; read clears only when none left.
// - Bit 6 resets 1; set only when transmit FIFO and shifter are empty.
// - Bit 5 resets 1; set when transmit FIFO empty, cleared by a write.
// - Transmit-empty interrupt raised while bit 5 set and enable bit 1 set.
// - Bit 4 set when line low over a character time; status read clears.
// - Break, framing and parity flags travel with characters, shown only when character reaches FIFO top.
// - Bit 3 set on missing stop bit; status read clears.
// - After framing error on a nonzero character, bad stop is taken as start, sampled again.
// - Bit 2 set on parity failure; status read clears.
// - Bit 1 set when character completes with receive FIFO full; read clears.
// - Overrun character is dropped; FIFO contents stay intact.
// - Bit 0 set while received data stored; cleared when data read out.
// - Modem bits 7..4 show inverted carrier, ring, set ready, clear send.
// - In loopback modem bits 7..4 mirror aux two, aux one, RTS, DTR.
// - Modem bit 3 set when carrier detect changes.
// - Modem bit 2 set when ring status goes from 0 to 1.
// - Modem bits 1,0 set when set ready or clear send changed.
// - Modem interrupt raised while any of modem bits 3..0 set.
// - Eight-bit scratch register, resets 0, affects nothing.
// - Loopback holds transmit pin high, ignores inputs, feeds transmitter to receiver.
module ulms_top (
    input  wire logic           core_clk,
    input  wire logic           reset_n,
    input  wire logic [2:0]     reg_addr,
    input  wire ulms_pkg::ulms_byte_t reg_wdata,
    input  wire logic           reg_wr,
    input  wire logic           reg_rd,
    output ulms_pkg::ulms_byte_t reg_rdata,
    input  wire logic           serial_rx_pin,
    output logic                serial_tx_pin,
    input  wire logic           carrier_detect_n,
    input  wire logic           ring_ind_n,
    input  wire logic           set_ready_n,
    input  wire logic           clear_send_n,
    output logic                dtr_n,
    output logic                rts_n,
    output logic                aux_out_one_n,
    output logic                aux_out_two_n,
    output logic                tx_empty_irq,
    output logic                modem_irq
);
    import ulms_pkg::*;

    localparam int DEPTH = `ULMS_FIFO_DEPTH;

    typedef struct packed {
        ulms_rx_e               rx_st;
        logic [6:0]             rx_tim;
        logic [2:0]             rx_bit;
        ulms_byte_t             rx_sh;
        logic                   rx_perr;
        logic [DEPTH-1:0][10:0] rx_mem;
        logic [3:0]             rx_wp;
        logic [3:0]             rx_rp;
        logic [4:0]             rx_n;
        logic [4:0]             err_n;
        logic                   top_seen;
        ulms_tx_e               tx_st;
        logic [6:0]             tx_tim;
        logic [3:0]             tx_bit;
        logic [9:0]             tx_sh;
        logic [DEPTH-1:0][7:0]  tx_mem;
        logic [3:0]             tx_wp;
        logic [3:0]             tx_rp;
        logic [4:0]             tx_n;
        logic                   tx_line;
        logic                   eif;
        logic                   brk;
        logic                   frm_err;
        logic                   par_err;
        logic                   ovr;
        ulms_byte_t             ier;
        ulms_byte_t             lcr;
        ulms_byte_t             modem_control_reg;
        ulms_byte_t             scr;
        logic [3:0]             lvl;
        logic [3:0]             delta;
        ulms_byte_t             rdata;
        logic                   tx_pin;
        logic [3:0]             mdm_out_n;
        logic                   txe_irq;
        logic                   mdm_irq;
    } ulms_state_s;

    ulms_state_s s_q;
    ulms_state_s s_d;

    logic       loop;
    logic       rxi;
    logic [3:0] cur;
    logic [3:0] mset;
    ulms_byte_t lstat_view;
    logic       rd_lstat;
    logic       rd_mstat;
    logic       rd_dat;
    logic       wr_dat;
    logic       rx_full;
    logic       tx_full;
    logic       rx_pop;

    assign loop = s_q.modem_control_reg[`ULMS_MCT_LOOP];
    // Loopback takes the receiver from our own transmit line
    assign rxi = loop ? s_q.tx_line : serial_rx_pin;
    assign cur = loop ? s_q.modem_control_reg[3:0]
                      : ~{carrier_detect_n, ring_ind_n, set_ready_n, clear_send_n};
    assign mset = {cur[3] ^ s_q.lvl[3],
                   cur[2] & ~s_q.lvl[2],
                   cur[1] ^ s_q.lvl[1], cur[0] ^ s_q.lvl[0]};
    assign rd_lstat = reg_rd && reg_addr == `ULMS_OFS_LST;
    assign rd_mstat = reg_rd && reg_addr == `ULMS_OFS_MST;
    assign rd_dat  = reg_rd && reg_addr == `ULMS_OFS_DATA;
    assign wr_dat  = reg_wr && reg_addr == `ULMS_OFS_DATA;
    assign rx_full = s_q.rx_n == 5'(DEPTH);
    assign tx_full = s_q.tx_n == 5'(DEPTH);
    assign rx_pop  = rd_dat && s_q.rx_n != 5'h00;
    assign lstat_view = {s_q.eif,
                       s_q.tx_n == 5'h00 && s_q.tx_st == ULMS_TX_IDLE,
                       s_q.tx_n == 5'h00,
                       s_q.brk, s_q.frm_err, s_q.par_err, s_q.ovr,
                       s_q.rx_n != 5'h00};

    always_comb
    begin
        logic        push;
        logic [10:0] word;
        logic        push_ok;
        logic        tx_pop;
        logic        par;
        push    = 1'b0;
        word    = 11'h000;
        push_ok = 1'b0;
        tx_pop  = 1'b0;
        par     = 1'b0;
        s_d     = s_q;
        s_d.rdata = 8'h00;

        // Register writes; status registers ignore writes
        if (reg_wr)
        begin
            case (reg_addr)
                `ULMS_OFS_IER: s_d.ier = reg_wdata;
                `ULMS_OFS_LCR: s_d.lcr = reg_wdata;
                `ULMS_OFS_MCT: s_d.modem_control_reg = reg_wdata;
                `ULMS_OFS_SCR: s_d.scr = reg_wdata;
                default:       ;
            endcase
        end

        // Register reads; data stands one cycle only
        if (reg_rd)
        begin
            case (reg_addr)
                `ULMS_OFS_DATA: s_d.rdata = s_q.rx_mem[s_q.rx_rp][7:0];
                `ULMS_OFS_IER:  s_d.rdata = s_q.ier;
                `ULMS_OFS_LCR:  s_d.rdata = s_q.lcr;
                `ULMS_OFS_MCT:  s_d.rdata = s_q.modem_control_reg;
                `ULMS_OFS_LST:  s_d.rdata = lstat_view;
                `ULMS_OFS_MST:  s_d.rdata = {s_q.lvl, s_q.delta};
                `ULMS_OFS_SCR:  s_d.rdata = s_q.scr;
                default:        s_d.rdata = 8'h00;
            endcase
        end

        // Receiver
        case (s_q.rx_st)
            ULMS_RX_IDLE:
            begin
                if (!rxi)
                begin
                    s_d.rx_st  = ULMS_RX_START;
                    s_d.rx_tim = 7'h00;
                end
            end
            ULMS_RX_START:
            begin
                if (s_q.rx_tim == 7'(`ULMS_HALF_CYC))
                begin
                    s_d.rx_tim = 7'h00;
                    s_d.rx_bit = 3'h0;
                    s_d.rx_st  = rxi ? ULMS_RX_IDLE : ULMS_RX_DATA;
                end
                else
                    s_d.rx_tim = s_q.rx_tim + 7'h01;
            end
            ULMS_RX_DATA:
            begin
                s_d.rx_tim = s_q.rx_tim + 7'h01;
                if (s_q.rx_tim == 7'(`ULMS_BIT_CYC - 1))
                begin
                    s_d.rx_tim = 7'h00;
                    s_d.rx_sh  = {rxi, s_q.rx_sh[7:1]};
                    s_d.rx_perr = 1'b0;
                    s_d.rx_bit = s_q.rx_bit + 3'h1;
                    if (s_q.rx_bit == 3'h7)
                        s_d.rx_st = s_q.lcr[`ULMS_LCR_PEN] ? ULMS_RX_PARITY : ULMS_RX_STOP;
                end
            end
            ULMS_RX_PARITY:
            begin
                s_d.rx_tim = s_q.rx_tim + 7'h01;
                if (s_q.rx_tim == 7'(`ULMS_BIT_CYC - 1))
                begin
                    s_d.rx_tim = 7'h00;
                    par = ^{s_q.rx_sh, rxi};
                    s_d.rx_perr = par == s_q.lcr[`ULMS_LCR_EPS];
                    s_d.rx_st = ULMS_RX_STOP;
                end
            end
            ULMS_RX_STOP:
            begin
                s_d.rx_tim = s_q.rx_tim + 7'h01;
                if (s_q.rx_tim == 7'(`ULMS_BIT_CYC - 1))
                begin
                    s_d.rx_tim = 7'h00;
                    if (rxi)
                    begin
                        push = 1'b1;
                        word = {2'b00, s_q.rx_perr, s_q.rx_sh};
                        s_d.rx_st = ULMS_RX_IDLE;
                    end
                    else if (s_q.rx_sh == 8'h00)
                        // All-zero frame may be a break; decide at character end
                        s_d.rx_st = ULMS_RX_HOLD;
                    else
                    begin
                        push = 1'b1;
                        word = {2'b01, s_q.rx_perr, s_q.rx_sh};
                        // Bad stop taken as next start, sampled again at once
                        s_d.rx_tim = 7'(`ULMS_HALF_CYC);
                        s_d.rx_st  = ULMS_RX_START;
                    end
                end
            end
            ULMS_RX_HOLD:
            begin
                s_d.rx_tim = s_q.rx_tim + 7'h01;
                if (rxi)
                begin
                    push = 1'b1;
                    word = {2'b01, s_q.rx_perr, 8'h00};
                    s_d.rx_st = ULMS_RX_IDLE;
                end
                else if (s_q.rx_tim == 7'(`ULMS_HALF_CYC))
                begin
                    push = 1'b1;
                    word = 11'h400;
                    s_d.rx_st = ULMS_RX_BRKEND;
                end
            end
            ULMS_RX_BRKEND:
            begin
                if (rxi)
                    s_d.rx_st = ULMS_RX_IDLE;
            end
            default: s_d.rx_st = ULMS_RX_IDLE;
        endcase

        // Status read clears first, so a same-cycle set below wins
        if (rd_lstat)
        begin
            s_d.brk     = 1'b0;
            s_d.frm_err = 1'b0;
            s_d.par_err = 1'b0;
            s_d.ovr = 1'b0;
        end

        // Top-of-FIFO reveal of stored error flags
        if (s_q.rx_n != 5'h00 && !s_q.top_seen)
        begin
            s_d.brk = s_d.brk | s_q.rx_mem[s_q.rx_rp][10];
            s_d.frm_err = s_d.frm_err | s_q.rx_mem[s_q.rx_rp][9];
            s_d.par_err = s_d.par_err | s_q.rx_mem[s_q.rx_rp][8];
            s_d.top_seen = 1'b1;
        end

        push_ok = push && !rx_full;
        if (push && rx_full)
            s_d.ovr = 1'b1;
        if (push_ok)
        begin
            s_d.rx_mem[s_q.rx_wp] = word;
            s_d.rx_wp = s_q.rx_wp + 4'h1;
        end
        if (rx_pop)
        begin
            s_d.rx_rp = s_q.rx_rp + 4'h1;
            s_d.top_seen = 1'b0;
        end
        s_d.rx_n  = s_q.rx_n + 5'(push_ok) - 5'(rx_pop);
        s_d.err_n = s_q.err_n + 5'(push_ok && word[10:8] != 3'h0)
                  - 5'(rx_pop && s_q.rx_mem[s_q.rx_rp][10:8] != 3'h0);
        if (rd_lstat && s_d.err_n == 5'h00)
            s_d.eif = 1'b0;
        if (push_ok && word[10:8] != 3'h0)
            s_d.eif = 1'b1;

        // Transmit FIFO fill; a write into a full FIFO is dropped
        if (wr_dat && !tx_full)
        begin
            s_d.tx_mem[s_q.tx_wp] = reg_wdata;
            s_d.tx_wp = s_q.tx_wp + 4'h1;
        end

        // Transmitter
        case (s_q.tx_st)
            ULMS_TX_IDLE:
            begin
                if (s_q.tx_n != 5'h00)
                begin
                    tx_pop      = 1'b1;
                    s_d.tx_rp   = s_q.tx_rp + 4'h1;
                    s_d.tx_line = 1'b0;
                    s_d.tx_tim  = 7'h00;
                    par = ^s_q.tx_mem[s_q.tx_rp] ^ ~s_q.lcr[`ULMS_LCR_EPS];
                    s_d.tx_sh = {1'b1, s_q.lcr[`ULMS_LCR_PEN] ? par : 1'b1,
                                 s_q.tx_mem[s_q.tx_rp]};
                    s_d.tx_bit = s_q.lcr[`ULMS_LCR_PEN] ? 4'hA : 4'h9;
                    s_d.tx_st  = ULMS_TX_SEND;
                end
            end
            ULMS_TX_SEND:
            begin
                s_d.tx_tim = s_q.tx_tim + 7'h01;
                if (s_q.tx_tim == 7'(`ULMS_BIT_CYC - 1))
                begin
                    s_d.tx_tim = 7'h00;
                    if (s_q.tx_bit == 4'h0)
                        s_d.tx_st = ULMS_TX_IDLE;
                    else
                    begin
                        s_d.tx_line = s_q.tx_sh[0];
                        s_d.tx_sh   = {1'b1, s_q.tx_sh[9:1]};
                        s_d.tx_bit  = s_q.tx_bit - 4'h1;
                    end
                end
            end
            default: s_d.tx_st = ULMS_TX_IDLE;
        endcase
        s_d.tx_n = s_q.tx_n + 5'(wr_dat && !tx_full) - 5'(tx_pop);

        // Modem status; set beats the read clear
        s_d.lvl = cur;
        if (rd_mstat)
            s_d.delta = 4'h0;
        s_d.delta = s_d.delta | mset;

        // Pins and interrupt requests, all from flops
        s_d.tx_pin    = loop ? 1'b1 : s_d.tx_line;
        s_d.mdm_out_n = loop ? 4'hF : ~s_d.modem_control_reg[3:0];
        s_d.txe_irq   = s_d.tx_n == 5'h00 && s_d.ier[`ULMS_IER_TXE];
        s_d.mdm_irq   = s_d.delta != 4'h0;
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_q           <= '0;
            s_q.rx_st     <= ULMS_RX_IDLE;
            s_q.tx_st     <= ULMS_TX_IDLE;
            s_q.tx_line   <= 1'b1;
            s_q.tx_pin    <= 1'b1;
            s_q.mdm_out_n <= 4'hF;
            s_q.ier       <= `ULMS_IER_RST;
            s_q.lcr       <= `ULMS_LCR_RST;
            s_q.modem_control_reg       <= `ULMS_MCT_RST;
            s_q.scr       <= `ULMS_SCR_RST;
        end
        else
            s_q <= s_d;
    end

    assign reg_rdata     = s_q.rdata;
    assign serial_tx_pin = s_q.tx_pin;
    assign dtr_n         = s_q.mdm_out_n[`ULMS_MCT_DTR];
    assign rts_n         = s_q.mdm_out_n[`ULMS_MCT_RTS];
    assign aux_out_one_n = s_q.mdm_out_n[`ULMS_MCT_AUX1];
    assign aux_out_two_n = s_q.mdm_out_n[`ULMS_MCT_AUX2];
    assign tx_empty_irq  = s_q.txe_irq;
    assign modem_irq     = s_q.mdm_irq;

    AST_ALL_EMPTY_NEEDS_FIFO_EMPTY: assert property (@(posedge core_clk) disable iff (!reset_n)
        lstat_view[`ULMS_LST_ALLE] |-> lstat_view[`ULMS_LST_TXFE])
        else $error("tx_all_empty set with data in transmit FIFO");

    AST_FIFO_EMPTY_CLEARS: assert property (@(posedge core_clk) disable iff (!reset_n)
        wr_dat && s_q.tx_n == 5'h00 |=> !lstat_view[`ULMS_LST_TXFE])
        else $error("tx_fifo_empty not cleared by a data write");

    AST_TX_IRQ: assert property (@(posedge core_clk) disable iff (!reset_n)
        lstat_view[`ULMS_LST_TXFE] && s_q.ier[`ULMS_IER_TXE] && !reg_wr |=> tx_empty_irq)
        else $error("transmit-empty interrupt missing");

    AST_OVERRUN: assert property (@(posedge core_clk) disable iff (!reset_n)
        $rose(s_q.ovr) |-> $past(rx_full))
        else $error("overrun flagged without a full receive FIFO");

    AST_OVR_SET: assert property (@(posedge core_clk) disable iff (!reset_n)
        rx_full && !rx_pop && s_d.rx_n == s_q.rx_n && s_q.rx_st == ULMS_RX_STOP && rxi
        && s_q.rx_tim == 7'(`ULMS_BIT_CYC - 1) |=> s_q.ovr && s_q.rx_n == 5'(DEPTH))
        else $error("overrun not flagged or full FIFO altered");

    AST_LOOP_PIN: assert property (@(posedge core_clk) disable iff (!reset_n)
        loop |=> serial_tx_pin && dtr_n && rts_n)
        else $error("loopback does not hold the pins high");

    AST_LOOP_MSR: assert property (@(posedge core_clk) disable iff (!reset_n)
        loop ##1 loop |-> s_q.lvl == $past(s_q.modem_control_reg[3:0]))
        else $error("loopback modem levels do not mirror modem control");

    AST_MSR_CLEAR: assert property (@(posedge core_clk) disable iff (!reset_n)
        rd_mstat && mset == 4'h0 ##1 mset == 4'h0 |-> s_q.delta == 4'h0 ##1 !modem_irq)
        else $error("modem status read did not clear change flags");

    AST_MODEM_IRQ: assert property (@(posedge core_clk) disable iff (!reset_n)
        s_q.delta != 4'h0 && !rd_mstat |=> modem_irq)
        else $error("modem interrupt missing");

    AST_SCRATCH: assert property (@(posedge core_clk) disable iff (!reset_n)
        reg_wr && reg_addr == `ULMS_OFS_SCR ##1 !reg_wr ##1 reg_rd && reg_addr == `ULMS_OFS_SCR
        |=> reg_rdata == $past(reg_wdata, 3))
        else $error("scratch register did not return written value");
endmodule

// ===== verif/ulms_term.sv
`timescale 1ns/1ns
module ulms_term (
    input  wire logic core_clk,
    output logic      serial_line,
    output logic      carrier_detect_n,
    output logic      ring_ind_n,
    output logic      set_ready_n,
    output logic      clear_send_n
);
    localparam int BIT_CYC = 86;

    initial
    begin
        serial_line = 1'b1;
        {carrier_detect_n, ring_ind_n, set_ready_n, clear_send_n} = 4'hF;
    end

    task automatic hold_bit(input logic v);
        serial_line <= v;
        repeat (BIT_CYC) @(posedge core_clk);
    endtask

    // Without a start the bits run on from a low stop, as a resyncing sender would
    task automatic send_frame(input logic [7:0] b, input logic with_start,
                              input logic par_en, input logic par_bad, input logic stop);
        if (with_start)
        begin
            @(posedge core_clk);
            hold_bit(1'b0);
        end
        for (int i = 0; i < 8; i++)
            hold_bit(b[i]);
        if (par_en)
            hold_bit(^b ^ par_bad);
        hold_bit(stop);
        if (stop)
            serial_line <= 1'b1;
    endtask

    task automatic send_break(input int bits);
        @(posedge core_clk);
        serial_line <= 1'b0;
        repeat (bits * BIT_CYC) @(posedge core_clk);
        serial_line <= 1'b1;
    endtask

    // Order is carrier, ring, set ready, clear send
    task automatic set_modem(input logic [3:0] lv_n);
        @(posedge core_clk);
        {carrier_detect_n, ring_ind_n, set_ready_n, clear_send_n} <= lv_n;
        repeat (4) @(posedge core_clk);
    endtask
endmodule

// ===== verif/testbench.sv
`timescale 1ns/1ns
`include "ulms_params.svh"
module testbench;
    import ulms_pkg::*;
    logic       core_clk;
    logic       reset_n;
    logic [2:0] reg_addr;
    ulms_byte_t reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    ulms_byte_t reg_rdata;
    logic       serial_rx_pin;
    logic       serial_tx_pin;
    logic       carrier_detect_n, ring_ind_n, set_ready_n, clear_send_n;
    logic       dtr_n, rts_n, aux_out_one_n, aux_out_two_n;
    logic       tx_empty_irq;
    logic       modem_irq;
    int         failures = 0;
    int         check_count = 0;
    int         cycles = 0;
    ulms_byte_t d;
    ulms_byte_t sent [16];

    ulms_top u_ulms_top (.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .serial_rx_pin(serial_rx_pin), .serial_tx_pin(serial_tx_pin),
        .carrier_detect_n(carrier_detect_n), .ring_ind_n(ring_ind_n),
        .set_ready_n(set_ready_n), .clear_send_n(clear_send_n), .dtr_n(dtr_n),
        .rts_n(rts_n), .aux_out_one_n(aux_out_one_n), .aux_out_two_n(aux_out_two_n),
        .tx_empty_irq(tx_empty_irq), .modem_irq(modem_irq));

    ulms_term u_ulms_term (.core_clk(core_clk), .serial_line(serial_rx_pin),
        .carrier_detect_n(carrier_detect_n), .ring_ind_n(ring_ind_n),
        .set_ready_n(set_ready_n), .clear_send_n(clear_send_n));

    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Frames and the overrun fill need roughly 23500 cycles
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 40000)
        begin
            failures++;
            finish_test();
        end
    end

    task automatic check(input ulms_byte_t seen, input ulms_byte_t exp);
        check_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic reg_write(input logic [2:0] a, input ulms_byte_t v);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // Data stands only in the cycle after the strobe
    task automatic expect_reg(input logic [2:0] a, input ulms_byte_t m, input ulms_byte_t exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        check(reg_rdata & m, exp);
    endtask

    function automatic ulms_byte_t lst_val(input logic eif, brk, frm, par, ovr, rdy);
        return {eif, 2'b11, brk, frm, par, ovr, rdy};
    endfunction

    function automatic ulms_byte_t mst_val(input logic [3:0] lv_n, input logic [3:0] dl);
        return {~lv_n, dl};
    endfunction

    initial
    begin
        reset_n = 1'b0;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        void'($urandom(32'he1ca));
        repeat (3) @(posedge core_clk);
        reset_n <= 1'b1;
        expect_reg(`ULMS_OFS_LST, 8'hFF, lst_val(0, 0, 0, 0, 0, 0));
        expect_reg(`ULMS_OFS_MST, 8'hFF, 8'h00);
        expect_reg(`ULMS_OFS_SCR, 8'hFF, 8'h00);
        expect_reg(3'h2, 8'hFF, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            d = 8'($urandom);
            reg_write(`ULMS_OFS_SCR, d);
            expect_reg(`ULMS_OFS_SCR, 8'hFF, d);
        end
        u_ulms_term.set_modem(4'h0);
        check(8'(modem_irq), 8'h01);
        expect_reg(`ULMS_OFS_MST, 8'hFF, mst_val(4'h0, 4'hF));
        expect_reg(`ULMS_OFS_MST, 8'hFF, mst_val(4'h0, 4'h0));
        check(8'(modem_irq), 8'h00);
        u_ulms_term.set_modem(4'h4);
        expect_reg(`ULMS_OFS_MST, 8'hFF, mst_val(4'h4, 4'h0));
        u_ulms_term.set_modem(4'hF);
        expect_reg(`ULMS_OFS_MST, 8'hFF, mst_val(4'hF, 4'hB));
        expect_reg(`ULMS_OFS_MST, 8'hFF, 8'h00);
        reg_write(`ULMS_OFS_MCT, 8'h1F);
        repeat (3) @(posedge core_clk);
        check(8'({serial_tx_pin, dtr_n, rts_n, aux_out_one_n, aux_out_two_n}), 8'h1F);
        expect_reg(`ULMS_OFS_MST, 8'hFF, mst_val(4'h0, 4'hF));
        reg_write(`ULMS_OFS_DATA, 8'hA5);
        for (int i = 0; i < 11; i++)
        begin
            repeat (100) @(posedge core_clk);
            check(8'(serial_tx_pin), 8'h01);
        end
        expect_reg(`ULMS_OFS_LST, 8'hFF, lst_val(0, 0, 0, 0, 0, 1));
        expect_reg(`ULMS_OFS_DATA, 8'hFF, 8'hA5);
        reg_write(`ULMS_OFS_MCT, 8'h0F);
        repeat (3) @(posedge core_clk);
        check(8'({serial_tx_pin, dtr_n, rts_n, aux_out_one_n, aux_out_two_n}), 8'h10);
        expect_reg(`ULMS_OFS_MST, 8'hFF, mst_val(4'hF, 4'hB));
        reg_write(`ULMS_OFS_MCT, 8'h00);
        reg_write(`ULMS_OFS_IER, 8'h02);
        repeat (3) @(posedge core_clk);
        check(8'(tx_empty_irq), 8'h01);
        reg_write(`ULMS_OFS_DATA, 8'($urandom));
        reg_write(`ULMS_OFS_DATA, 8'($urandom));
        expect_reg(`ULMS_OFS_LST, 8'h60, 8'h00);
        check(8'(tx_empty_irq), 8'h00);
        repeat (2000) @(posedge core_clk);
        expect_reg(`ULMS_OFS_LST, 8'hFF, 8'h60);
        check(8'(tx_empty_irq), 8'h01);
        reg_write(`ULMS_OFS_IER, 8'h00);
        // A clean byte ahead of a bad one keeps its flag hidden
        reg_write(`ULMS_OFS_LCR, 8'h18);
        sent[0] = 8'($urandom);
        sent[1] = 8'($urandom);
        u_ulms_term.send_frame(sent[0], 1, 1, 0, 1);
        u_ulms_term.send_frame(sent[1], 1, 1, 1, 1);
        repeat (50) @(posedge core_clk);
        expect_reg(`ULMS_OFS_LST, 8'hFF, lst_val(1, 0, 0, 0, 0, 1));
        expect_reg(`ULMS_OFS_DATA, 8'hFF, sent[0]);
        expect_reg(`ULMS_OFS_LST, 8'hFF, lst_val(1, 0, 0, 1, 0, 1));
        expect_reg(`ULMS_OFS_DATA, 8'hFF, sent[1]);
        expect_reg(`ULMS_OFS_LST, 8'h7F, 8'h60);
        expect_reg(`ULMS_OFS_LST, 8'hFF, 8'h60);
        reg_write(`ULMS_OFS_LCR, 8'h00);
        sent[0] = 8'($urandom) | 8'h01;
        u_ulms_term.send_frame(sent[0], 1, 0, 0, 0);
        u_ulms_term.send_frame(sent[1], 0, 0, 0, 1);
        repeat (50) @(posedge core_clk);
        expect_reg(`ULMS_OFS_LST, 8'hFF, lst_val(1, 0, 1, 0, 0, 1));
        expect_reg(`ULMS_OFS_DATA, 8'hFF, sent[0]);
        expect_reg(`ULMS_OFS_LST, 8'h7F, 8'h61);
        expect_reg(`ULMS_OFS_DATA, 8'hFF, sent[1]);
        expect_reg(`ULMS_OFS_LST, 8'hFF, 8'h60);
        u_ulms_term.send_break(20);
        repeat (200) @(posedge core_clk);
        expect_reg(`ULMS_OFS_LST, 8'hFF, lst_val(1, 1, 0, 0, 0, 1));
        expect_reg(`ULMS_OFS_DATA, 8'hFF, 8'h00);
        expect_reg(`ULMS_OFS_LST, 8'h7F, 8'h60);
        expect_reg(`ULMS_OFS_LST, 8'hFF, 8'h60);
        for (int i = 0; i < 17; i++)
        begin
            d = 8'($urandom);
            if (i < 16)
                sent[i] = d;
            u_ulms_term.send_frame(d, 1, 0, 0, 1);
        end
        repeat (50) @(posedge core_clk);
        expect_reg(`ULMS_OFS_LST, 8'hFF, lst_val(0, 0, 0, 0, 1, 1));
        for (int i = 0; i < 16; i++)
            expect_reg(`ULMS_OFS_DATA, 8'hFF, sent[i]);
        expect_reg(`ULMS_OFS_LST, 8'hFF, 8'h60);
        finish_test();
    end
endmodule
